// ---- nvs_master_bfm.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behavioural bus master; open drain, so it can only pull data low
module nvs_master_bfm (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   logic busy;
   // Idle bus: clock parked high, data released
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
      busy = 1'b0;
   end
   // Moves just off a system clock edge so nothing races the sampling edge
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Clock pulse with data high on an idle bus, walks the link out of reset
   task automatic tick();
      o_scl = 1'b0;
      step(5);
      o_scl = 1'b1;
      step(5);
   endtask
   // One slot; data moves a cycle after the fall so it never looks like a start or stop
   task automatic bit_slot(input logic b, output logic r);
      o_scl = 1'b0;
      step(1);
      o_sda_low = !b;
      step(4);
      o_scl = 1'b1;
      step(3);
      r = i_sda;
      step(2);
   endtask
   // Start, or repeated start when a frame is open
   task automatic start();
      if (busy) begin
         o_scl = 1'b0;
         step(1);
         o_sda_low = 1'b0;
         step(4);
         o_scl = 1'b1;
         step(5);
      end
      o_sda_low = 1'b1;
      step(5);
      busy = 1'b1;
   endtask
   // Stop leaves the clock standing high
   task automatic stop();
      o_scl = 1'b0;
      step(1);
      o_sda_low = 1'b1;
      step(4);
      o_scl = 1'b1;
      step(5);
      o_sda_low = 1'b0;
      step(5);
      busy = 1'b0;
   endtask
   // Byte most significant bit first, then the ninth slot carrying mack
   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic sack);
      for (int i = 7; i >= 0; i--) begin
         bit_slot(d[i], r[i]);
      end
      bit_slot(mack, sack);
   endtask
endmodule
`default_nettype wire

// ---- nvs_pkg.sv ----
package nvs_pkg;
   // Address word fields
   localparam logic [3:0] NVS_TYPE_CODE = 4'ha;
   localparam logic [7:0] NVS_ID_SEL = 8'hf8;
   localparam logic [7:0] NVS_ID_READ = 8'hf9;
   localparam logic [4:0] NVS_HS_CODE = 5'h01;
   // Array geometry
   localparam int NVS_ADDR_W = 15;
   // Bit positions within a nine-clock byte slot, and the index of the last identifier byte
   localparam logic [3:0] NVS_BIT_LAST = 4'h7;
   localparam logic [3:0] NVS_BIT_ACK = 4'h8;
   localparam logic [1:0] NVS_ID_LAST = 2'h2;
   // Protocol phases
   typedef enum logic [3:0] {
      PH_IDLE, PH_DEV, PH_AHI, PH_ALO, PH_WR, PH_RD, PH_IDSEL, PH_IDRD, PH_IGN
   } nvs_phase_e;
   // Engine state carried as one bundle
   typedef struct packed {
      nvs_phase_e phase;
      nvs_phase_e nph;
      logic [3:0] cnt;
      logic ack;
      logic oe;
      logic hs;
      logic armed;
      logic [1:0] idx;
      logic [7:0] rx;
      logic [7:0] txd;
   } nvs_state_s;
   localparam nvs_state_s NVS_STATE_RST = '{PH_IDLE, PH_IDLE, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 8'h00, 8'h00};
endpackage

// ---- nvs_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvs_slave
   import nvs_pkg::*;
#(
   parameter int ADDR_W = NVS_ADDR_W,
   parameter logic [7:0] ID_BYTE0 = 8'h5a, // Arbitrary value
   parameter logic [7:0] ID_BYTE1 = 8'h3c, // Arbitrary value
   parameter logic [7:0] ID_BYTE2 = 8'h81  // Arbitrary value
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_address_strap_2,
   input wire logic i_address_strap_1,
   input wire logic i_address_strap_0,
   input wire logic i_write_protect_in,
   output logic o_sda_out,
   output logic o_sda_oe,
   output logic o_hs_mode
);
   localparam int DEPTH = 2 ** ADDR_W;

   // High address byte must leave its top bit unused
   if (ADDR_W < 9 || ADDR_W > 15) begin : g_chk
      $error("ADDR_W must lie in 9..15");
   end

   // Link domain: sample data on each clock rise, flag it by toggle
   // Reset reaches the link two scl rises late; clock the idle bus after release
   logic lrst_s1, lrst_s2, lbit_r, ltog_r;
   always_ff @(posedge i_scl) begin
      lrst_s1 <= i_sys_rst;
      lrst_s2 <= lrst_s1;
   end
   always_ff @(posedge i_scl) begin
      if (lrst_s2) begin
         lbit_r <= 1'b0;
         ltog_r <= 1'b0;
      end else begin
         lbit_r <= i_sda;
         ltog_r <= ~ltog_r;
      end
   end

   // Pin synchronisers; stage 3 only feeds edge detection
   logic [5:0] pin_s1, pin_s2;
   logic [1:0] pin_s3;
   logic tog_s1, tog_s2, tog_s3;
   always_ff @(posedge i_clk) begin
      pin_s1 <= {i_scl, i_sda, i_address_strap_2, i_address_strap_1, i_address_strap_0, i_write_protect_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2[5:4];
      tog_s1 <= ltog_r;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
   end

   // Bus events; the sampled bit is stable long after its toggle lands
   logic scl_h, start_ev, stop_ev, fall_ev, bit_ev, wp;
   logic [2:0] strap;
   always_comb begin
      scl_h = pin_s2[5] & pin_s3[1];
      start_ev = scl_h & pin_s3[0] & ~pin_s2[4];
      stop_ev = scl_h & ~pin_s3[0] & pin_s2[4];
      fall_ev = pin_s3[1] & ~pin_s2[5];
      bit_ev = tog_s2 ^ tog_s3;
      strap = pin_s2[3:1];
      wp = pin_s2[0];
   end

   // Memory array, read every cycle at the current address
   // Synchronous read keeps the array inferable as block memory
   logic [7:0] mem [0:DEPTH-1];
   logic [7:0] rd_r;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic we;
   nvs_state_s st_r, st_nxt;
   always_ff @(posedge i_clk) begin
      if (we) begin
         mem[addr_r] <= st_r.rx;
      end
      rd_r <= mem[addr_r];
   end

   // Protocol engine next state
   logic [7:0] byte_in, payload, src;
   logic dev_match;
   always_comb begin
      st_nxt = st_r;
      addr_nxt = addr_r;
      we = 1'b0;
      byte_in = {st_r.rx[6:0], lbit_r};
      dev_match = (byte_in[7:4] == NVS_TYPE_CODE) && (byte_in[3:1] == strap);
      case (st_r.idx)
         2'h0: payload = ID_BYTE0;
         2'h1: payload = ID_BYTE1;
         default: payload = ID_BYTE2;
      endcase
      if (st_r.phase == PH_RD) begin
         payload = rd_r;
      end
      // First bit comes straight from the payload, later ones from the latch
      src = (st_r.cnt == 4'h0) ? payload : st_r.txd;
      // Start outranks everything so a repeated start always reframes
      if (start_ev) begin
         st_nxt.phase = PH_DEV;
         st_nxt.cnt = 4'h0;
         st_nxt.ack = 1'b0;
         st_nxt.oe = 1'b0;
      end else if (stop_ev) begin
         // Stop abandons any byte in flight and drops high speed
         st_nxt = NVS_STATE_RST;
      end else if (bit_ev && st_r.phase != PH_IDLE && st_r.phase != PH_IGN) begin
         if (st_r.cnt != NVS_BIT_ACK) begin
            st_nxt.rx = byte_in;
            st_nxt.cnt = st_r.cnt + 4'h1;
            if (st_r.cnt == NVS_BIT_LAST) begin
               st_nxt.ack = 1'b1;
               st_nxt.nph = st_r.phase;
               case (st_r.phase)
                  PH_DEV: begin
                     st_nxt.armed = 1'b0;
                     if (byte_in == NVS_ID_SEL) begin
                        st_nxt.nph = PH_IDSEL;
                     end else if (byte_in == NVS_ID_READ && st_r.armed) begin
                        st_nxt.nph = PH_IDRD;
                        st_nxt.idx = 2'h0;
                     end else if (byte_in[7:3] == NVS_HS_CODE) begin
                        st_nxt.hs = 1'b1;
                        st_nxt.ack = 1'b0;
                        st_nxt.nph = PH_IGN;
                     end else if (dev_match) begin
                        st_nxt.nph = byte_in[0] ? PH_RD : PH_AHI;
                     end else begin
                        st_nxt.ack = 1'b0;
                        st_nxt.nph = PH_IGN;
                     end
                  end
                  PH_IDSEL: begin
                     // Direction bit is a don't care here
                     st_nxt.ack = dev_match;
                     st_nxt.armed = dev_match;
                     st_nxt.nph = PH_IGN;
                  end
                  PH_AHI: st_nxt.nph = PH_ALO;
                  PH_ALO: st_nxt.nph = PH_WR;
                  PH_WR: st_nxt.nph = PH_WR;
                  default: st_nxt.ack = 1'b0;
               endcase
            end
         end else begin
            // Ninth clock: act on the finished byte
            st_nxt.cnt = 4'h0;
            st_nxt.ack = 1'b0;
            case (st_r.phase)
               PH_RD: begin
                  addr_nxt = addr_r + 1'b1;
                  st_nxt.phase = lbit_r ? PH_IGN : PH_RD;
               end
               PH_IDRD: begin
                  st_nxt.idx = (st_r.idx == NVS_ID_LAST) ? 2'h0 : st_r.idx + 2'h1;
                  st_nxt.phase = lbit_r ? PH_IGN : PH_IDRD;
               end
               PH_AHI: begin
                  addr_nxt[ADDR_W-1:8] = st_r.rx[ADDR_W-9:0];
                  st_nxt.phase = st_r.nph;
               end
               PH_ALO: begin
                  addr_nxt[7:0] = st_r.rx;
                  st_nxt.phase = st_r.nph;
               end
               PH_WR: begin
                  we = ~wp;
                  addr_nxt = addr_r + 1'b1;
                  st_nxt.phase = st_r.nph;
               end
               default: st_nxt.phase = st_r.nph;
            endcase
         end
      end else if (fall_ev) begin
         // Data changes only while the clock is low
         if (st_r.cnt == NVS_BIT_ACK) begin
            st_nxt.oe = st_r.ack;
         end else if (st_r.phase == PH_RD || st_r.phase == PH_IDRD) begin
            if (st_r.cnt == 4'h0) begin
               st_nxt.txd = payload;
            end
            st_nxt.oe = ~src[3'(4'h7 - st_r.cnt)];
         end else begin
            st_nxt.oe = 1'b0;
         end
      end
   end

   // Engine registers; address resets to zero in place of unknown
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st_r <= NVS_STATE_RST;
         addr_r <= '0;
      end else begin
         st_r <= st_nxt;
         addr_r <= addr_nxt;
      end
   end

   // Open drain: only ever pulls low, never drives high
   assign o_sda_out = 1'b0;
   assign o_sda_oe = st_r.oe;
   assign o_hs_mode = st_r.hs;

   // Checks
   a_stop_standby: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      stop_ev |=> st_r.phase == PH_IDLE && !st_r.hs && !st_r.oe) else $error("stop did not idle");
   a_hs_leave: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $fell(st_r.hs) |-> $past(stop_ev)) else $error("hs left without stop");
   a_start_dev: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      start_ev |=> st_r.phase == PH_DEV && st_r.cnt == 4'h0) else $error("start not framed");
   a_type_reject: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (bit_ev && !start_ev && !stop_ev && st_r.phase == PH_DEV && st_r.cnt == NVS_BIT_LAST && !dev_match
       && byte_in[7:4] != 4'h0 && byte_in[7:3] != 5'h1f) |=> !st_r.ack && st_r.nph == PH_IGN)
      else $error("bad address word acked");
   a_hs_nack: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (bit_ev && !start_ev && !stop_ev && st_r.phase == PH_DEV && st_r.cnt == NVS_BIT_LAST
       && byte_in[7:3] == NVS_HS_CODE) |=> st_r.hs && !st_r.ack) else $error("hs code mishandled");
   a_wp_block: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      we |-> !wp && st_r.phase == PH_WR && st_r.cnt == NVS_BIT_ACK) else $error("write while protected");
   a_addr_wrap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (we && &addr_r) |=> addr_r == '0) else $error("write address did not wrap");
   a_rd_incr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (bit_ev && !start_ev && !stop_ev && st_r.phase == PH_RD && st_r.cnt == NVS_BIT_ACK)
      |=> addr_r == $past(addr_r) + 1'b1) else $error("read address not advanced");
   a_ack_drive: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (fall_ev && !bit_ev && !start_ev && !stop_ev && st_r.cnt == NVS_BIT_ACK && st_r.ack)
      |=> o_sda_oe) else $error("ack not driven low");
   a_id_wrap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (bit_ev && !start_ev && !stop_ev && st_r.phase == PH_IDRD && st_r.cnt == NVS_BIT_ACK
       && st_r.idx == NVS_ID_LAST) |=> st_r.idx == 2'h0) else $error("id did not restart");

   // Acks and data moves
   // A matching word is acked at once, even right after a write
   a_poll_ack: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (bit_ev && !start_ev && !stop_ev && st_r.phase == PH_DEV && st_r.cnt == NVS_BIT_LAST && dev_match)
      |=> st_r.ack) else $error("matching word not acked");
   // Driven data may only move after a clock fall, start or stop
   a_oe_on_fall: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $changed(o_sda_oe) |-> $past(fall_ev || start_ev || stop_ev)) else $error("data moved off a fall");
   // Line released in an ack slot the device does not own
   a_ack_release: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (fall_ev && !bit_ev && !start_ev && !stop_ev && st_r.cnt == NVS_BIT_ACK && !st_r.ack)
      |=> !o_sda_oe) else $error("ack slot not released");
   // Idle device never holds the line, so a lost stop cannot jam it
   a_idle_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      st_r.phase == PH_IDLE |-> !o_sda_oe) else $error("line held while idle");

   // Address and data paths
   // High byte top bit is dropped; the rest lands above bit 7
   a_addr_hi: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (bit_ev && !start_ev && !stop_ev && st_r.phase == PH_AHI && st_r.cnt == NVS_BIT_ACK)
      |=> addr_r[ADDR_W-1:8] == $past(st_r.rx[ADDR_W-9:0])) else $error("high address not taken");
   a_addr_lo: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (bit_ev && !start_ev && !stop_ev && st_r.phase == PH_ALO && st_r.cnt == NVS_BIT_ACK)
      |=> addr_r[7:0] == $past(st_r.rx)) else $error("low address not taken");
   // Unprotected data byte commits on its own ack clock
   a_write_commit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (bit_ev && !start_ev && !stop_ev && st_r.phase == PH_WR && st_r.cnt == NVS_BIT_ACK && !wp)
      |-> we) else $error("data byte not committed");
   // Nack from the master ends the read
   a_rd_nack_end: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (bit_ev && !start_ev && !stop_ev && st_r.phase == PH_RD && st_r.cnt == NVS_BIT_ACK && lbit_r)
      |=> st_r.phase == PH_IGN) else $error("read ran past nack");
   // Identifier read without the select word is refused
   a_id_armed: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (bit_ev && !start_ev && !stop_ev && st_r.phase == PH_DEV && st_r.cnt == NVS_BIT_LAST
       && byte_in == NVS_ID_READ && !st_r.armed) |=> !st_r.ack && st_r.nph == PH_IGN)
      else $error("identifier read without select");
endmodule
`default_nettype wire

// ---- tb_i2c_nv_memory_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_i2c_nv_memory_slave;
   localparam logic [7:0] ID0 = 8'h12; // Arbitrary value
   localparam logic [7:0] ID1 = 8'h34; // Arbitrary value
   localparam logic [7:0] ID2 = 8'h56; // Arbitrary value
   localparam logic [7:0] DW = 8'hac; // Type 1010, straps 110, write
   localparam logic [7:0] DR = 8'had; // Same, read
   logic clk, rst, wp, scl, m_low, sda_w, oe, so, hs, ak;
   logic [7:0] rd;
   int errors, cmp_count, cyc;
   // Pull-up on the data wire; either side may pull it low
   assign sda_w = !((oe && !so) || m_low);
   nvs_slave #(.ID_BYTE0(ID0), .ID_BYTE1(ID1), .ID_BYTE2(ID2)) DUT (.i_clk(clk), .i_sys_rst(rst),
      .i_scl(scl), .i_sda(sda_w), .i_address_strap_2(1'b1), .i_address_strap_1(1'b1),
      .i_address_strap_0(1'b0), .i_write_protect_in(wp), .o_sda_out(so), .o_sda_oe(oe), .o_hs_mode(hs));
   nvs_master_bfm m (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(m_low));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Hang guard, far above the few thousand cycles the sequence needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Master writes a byte; slave ack expected when want is high
   task automatic send(input logic [7:0] d, input logic want);
      m.xfer(d, 1'b1, rd, ak);
      `CHK(ak, !want)
   endtask
   // Slave supplies a byte; mack high ends the read
   task automatic recv(input logic mack, input logic [7:0] exp);
      m.xfer(8'hff, mack, rd, ak);
      `CHK(rd, exp)
   endtask
   task automatic seek(input logic [7:0] hi, input logic [7:0] lo);
      m.start();
      send(DW, 1'b1);
      send(hi, 1'b1);
      send(lo, 1'b1);
   endtask
   task automatic rd_at(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] exp);
      seek(hi, lo);
      m.start();
      send(DR, 1'b1);
      recv(1'b1, exp);
      m.stop();
   endtask
   initial begin
      rst = 1'b1;
      wp = 1'b0;
      errors = 0;
      cmp_count = 0;
      cyc = 0;
      // Link domain needs clock edges to see its reset
      repeat (3) m.tick();
      rst = 1'b0;
      // Link reset lingers two scl rises, so clock the idle bus past it
      repeat (2) m.tick();
      m.step(5);
      // Page write across the top of the array
      seek(8'h7f, 8'hfe);
      for (int i = 0; i < 4; i++) begin
         send(8'hd0 + i[7:0], 1'b1);
      end
      m.stop();
      // Sequential read wraps; current read then follows the last address
      seek(8'h7f, 8'hfe);
      m.start();
      send(DR, 1'b1);
      for (int i = 0; i < 3; i++) begin
         recv(i == 2, 8'hd0 + i[7:0]);
      end
      m.stop();
      m.start();
      send(DR, 1'b1);
      recv(1'b1, 8'hd3);
      m.stop();
      // Protected write is acked but dropped; top address bit ignored
      wp = 1'b1;
      seek(8'h00, 8'h01);
      send(8'h55, 1'b1);
      m.stop();
      wp = 1'b0;
      rd_at(8'h80, 8'h01, 8'hd3);
      // Stop in mid byte abandons the write
      seek(8'h00, 8'h00);
      for (int i = 0; i < 4; i++) begin
         m.bit_slot(1'b0, ak);
      end
      m.stop();
      rd_at(8'h00, 8'h00, 8'hd2);
      // Foreign type code and reversed straps are ignored
      m.start();
      send(8'hbc, 1'b0);
      send(8'h00, 1'b0);
      m.stop();
      m.start();
      send(8'ha6, 1'b0);
      m.stop();
      // High speed entry and exit
      m.start();
      send(8'h09, 1'b0);
      `CHK(hs, 1'b1)
      m.stop();
      m.step(5);
      `CHK(hs, 1'b0)
      `CHK(so, 1'b0)
      // Identifier read, acked past the last byte to see it restart
      m.start();
      send(8'hf8, 1'b1);
      send(DR, 1'b1);
      m.start();
      send(8'hf9, 1'b1);
      recv(1'b0, ID0);
      recv(1'b0, ID1);
      recv(1'b0, ID2);
      recv(1'b1, ID0);
      m.stop();
      complete_run();
   end
endmodule
`default_nettype wire
